/* File: hdl/scp_cfg.svh */
// Purpose: constants of the serial configuration port, both ends
// Assumes: 50 MHz system clock on both ends
// Notes: register offsets are 5-bit serial addresses
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
`define SCP_ADDR_W 5
`define SCP_NREG 32
`define SCP_REG_RESET 8'h00
// implemented addresses: 0x05, 0x0B..0x11
`define SCP_IMPL_MASK 32'h0003F820
`define SCP_ADDR_CTRL 5'h05
`define SCP_BIT_FOUR_WIRE 7
`define SCP_ADDR_VCO 5'h0B
`define SCP_ADDR_OFFA_HI 5'h0C
`define SCP_ADDR_OFFA_LO 5'h0D
`define SCP_ADDR_OUTSEL 5'h0E
`define SCP_ADDR_RSVD_F 5'h0F
`define SCP_ADDR_OFFB_HI 5'h10
`define SCP_ADDR_OFFB_LO 5'h11
`define SCP_BIT_OFFSET_SYNC 5
// instruction byte fields
`define SCP_INS_RW 7
`define SCP_INS_CNT_MSB 6
`define SCP_INS_CNT_LSB 5
`define SCP_INS_ADDR_MSB 4
// output select codes
`define SCP_SEL_PLL 3'h1
`define SCP_SEL_DLL 3'h2
`define SCP_SEL_PAT 3'h3
`define SCP_SEL_FIFO 3'h4
`define SCP_SEL_SELF 3'h5
// field positions inside registers
`define SCP_SEL_MSB 7
`define SCP_SEL_LSB 5
`define SCP_VCO_RANGE_MSB 3
`define SCP_VCO_GAIN_MSB 5
`define SCP_VCO_GAIN_LSB 4
// timing
`define SCP_CLK_NS 20
`define SCP_SCLK_HALF_NS 80
`define SCP_HALF_SCLK ((`SCP_SCLK_HALF_NS) / (`SCP_CLK_NS))
`define SCP_MIN_HALF 4
`endif

/* File: hdl/scp_pkg.sv */
// Purpose: shared types of the serial configuration port
// Assumes: nothing
// Notes: constants live in scp_cfg.svh
package scp_pkg;
  typedef logic [7:0] scp_byte_t; // one serial byte
  typedef enum logic [1:0] {D_INSTR, D_DATA, D_DONE} scp_dev_ph_e; // device frame phase
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_RUN, H_TRAIL, H_GAP} scp_host_st_e; // host states
endpackage : scp_pkg

/* File: hdl/scp_link_if.sv */
// Purpose: serial link between host and device ends
// Assumes: undriven data lines float high (weak pull-up)
// Notes: resolves the shared data pin from both output enables
`timescale 1ns/10ps
interface scp_link_if;
  logic sclk; // serial clock, host driven
  logic frame_enable_n; // frame enable, active low
  logic sdio_h_o; // host data out
  logic sdio_h_oe; // host drives shared data pin
  logic sdio_d_o; // device data out
  logic sdio_d_oe; // device drives shared data pin
  logic sdo_o; // device serial output pin value
  logic sdo_oe; // device drives serial output pin
  logic sdio_line; // resolved shared data pin
  logic sdo_line; // resolved serial output pin
  // host wins a collision; idle line reads high
  assign sdio_line = sdio_h_oe ? sdio_h_o : (sdio_d_oe ? sdio_d_o : 1'b1);
  assign sdo_line = sdo_oe ? sdo_o : 1'b1;
  modport dev_mp (input sclk, frame_enable_n, sdio_line,
                  output sdio_d_o, sdio_d_oe, sdo_o, sdo_oe);
  modport host_mp (output sclk, frame_enable_n, sdio_h_o, sdio_h_oe,
                   input sdio_line, sdo_line);
endinterface : scp_link_if

/* File: hdl/scp_dev.sv */
// Purpose: device end of the serial configuration port with offset sync
// Assumes: serial pins are asynchronous to CLK and resynchronised here
// Notes: serial clock must stay below CLK/8 per phase; see scp_cfg.svh
//
// Summary of operation
// - mode bit picks 3-pin or 4-pin port
// - 3-pin shares data pin; 4-pin splits output
// - sample on rising, launch on falling clock
// - host frames 2 to 5 bytes
// - instruction bit 7 high means read
// - bits 6:5 give one to four bytes
// - all bytes travel most significant bit first
// - address bits 4:0, decrement per byte
// - 4-pin read ends low until frame closes
// - sync rising edge loads both working offsets
// - sync bit stays set; software clears it
// - offset A split over 0x0C and 0x0D
// - select field routes status to output pin
// - 4-pin status select overrides read data
// - VCO range code sets bias current
// - reserved bits and register written zero
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "scp_cfg.svh"
module scp_dev
  import scp_pkg::*;
(
  input wire logic CLK, // system clock
  input wire logic RESET, // synchronous reset, active high
  scp_link_if.dev_mp LINK, // serial pins
  input wire logic PLL_LOCK, // status: pll locked
  input wire logic DLL_LOCK, // status: dll locked
  input wire logic PATTERN_ERR, // status: pattern error
  input wire logic FIFO_ERR, // status: fifo error
  input wire logic SELF_CHECK_ERROR, // status: self test error
  output logic [12:0] PATH_A_OFFSET, // working offset, path A
  output logic [12:0] PATH_B_OFFSET, // working offset, path B
  output logic [3:0] VCO_RANGE, // vco bias range field
  output logic [1:0] VCO_GAIN, // vco gain field
  output logic FOUR_WIRE_SELECT // current port mode
);
  localparam logic [31:0] IMPL = `SCP_IMPL_MASK; // implemented addresses

  scp_byte_t regs_q [0:`SCP_NREG-1]; // register file
  logic sclk_m_q, sclk_s_q, sclk_p_q; // serial clock synchroniser and history
  logic fen_m_q, fen_s_q; // frame enable synchroniser
  logic sdi_m_q, sdi_s_q; // data in synchroniser
  logic rise, fall, active; // decoded link events
  scp_byte_t in_byte; // byte including the bit arriving now
  scp_dev_ph_e ph_q; // frame phase
  logic [2:0] bit_q; // bit within byte
  logic [6:0] rx_q; // bits received so far
  logic rw_q; // frame is a read
  logic [1:0] left_q; // data bytes remaining minus one
  logic [`SCP_ADDR_W-1:0] addr_q; // current register address
  scp_byte_t tx_q; // read shifter
  logic rd_act_q; // read data being launched
  logic rd_bit_q; // current read bit
  logic tail_q; // read finished, pin held low
  logic sync_prev_q; // previous offset sync level
  logic four_wire; // port mode from control register
  logic [2:0] out_sel; // output pin source select

  // read mux; unimplemented addresses read zero
  function automatic scp_byte_t rd_val(input logic [`SCP_ADDR_W-1:0] a);
    rd_val = IMPL[a] ? regs_q[a] : 8'h00;
  endfunction : rd_val

  assign four_wire = regs_q[`SCP_ADDR_CTRL][`SCP_BIT_FOUR_WIRE];
  assign out_sel = regs_q[`SCP_ADDR_OUTSEL][`SCP_SEL_MSB:`SCP_SEL_LSB];
  assign rise = sclk_s_q & ~sclk_p_q;
  assign fall = ~sclk_s_q & sclk_p_q;
  assign active = ~fen_s_q;
  assign in_byte = {rx_q, sdi_s_q};
  assign VCO_RANGE = regs_q[`SCP_ADDR_VCO][`SCP_VCO_RANGE_MSB:0];
  assign VCO_GAIN = regs_q[`SCP_ADDR_VCO][`SCP_VCO_GAIN_MSB:`SCP_VCO_GAIN_LSB];
  assign FOUR_WIRE_SELECT = four_wire;

  // two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      fen_m_q <= 1'b1;
      fen_s_q <= 1'b1;
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end
    else
    begin
      sclk_m_q <= LINK.sclk;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      fen_m_q <= LINK.frame_enable_n;
      fen_s_q <= fen_m_q;
      sdi_m_q <= LINK.sdio_line;
      sdi_s_q <= sdi_m_q;
    end
  end

  // frame engine: instruction decode, address walk, read shifter
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ph_q <= D_INSTR;
      bit_q <= 3'h0;
      rx_q <= 7'h00;
      rw_q <= 1'b0;
      left_q <= 2'h0;
      addr_q <= '0;
      tx_q <= 8'h00;
      rd_act_q <= 1'b0;
      rd_bit_q <= 1'b0;
      tail_q <= 1'b0;
    end
    else if (!active)
    begin
      // frame closed: any partial byte is simply dropped
      ph_q <= D_INSTR;
      bit_q <= 3'h0;
      rd_act_q <= 1'b0;
      tail_q <= 1'b0;
    end
    else if (rise && ph_q != D_DONE)
    begin
      rx_q <= in_byte[6:0];
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7)
      begin
        unique case (ph_q)
          D_INSTR:
          begin
            rw_q <= in_byte[`SCP_INS_RW];
            left_q <= in_byte[`SCP_INS_CNT_MSB:`SCP_INS_CNT_LSB];
            addr_q <= in_byte[`SCP_INS_ADDR_MSB:0];
            tx_q <= rd_val(in_byte[`SCP_INS_ADDR_MSB:0]);
            ph_q <= D_DATA;
          end
          D_DATA:
          begin
            // next byte goes to the address below
            addr_q <= addr_q - 5'h01;
            tx_q <= rd_val(addr_q - 5'h01);
            left_q <= left_q - 2'h1;
            if (left_q == 2'h0)
            begin
              ph_q <= D_DONE;
            end
          end
          D_DONE:
          begin
            ph_q <= D_DONE;
          end
        endcase
      end
    end
    else if (fall && rw_q && ph_q == D_DATA)
    begin
      // launch next read bit, msb first
      rd_bit_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
      rd_act_q <= 1'b1;
    end
    else if (fall && rw_q && ph_q == D_DONE)
    begin
      rd_act_q <= 1'b0;
      tail_q <= 1'b1;
    end
  end

  // register writes land only on a complete data byte
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      for (int i = 0; i < `SCP_NREG; i++)
      begin
        regs_q[i] <= `SCP_REG_RESET;
      end
    end
    else if (active && rise && ph_q == D_DATA && bit_q == 3'h7 && !rw_q && IMPL[addr_q])
    begin
      // reserved bits are stored as written; software keeps them zero
      regs_q[addr_q] <= in_byte;
    end
  end

  // double buffered offsets, loaded on a rising sync bit only
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sync_prev_q <= 1'b0;
      PATH_A_OFFSET <= 13'h0000;
      PATH_B_OFFSET <= 13'h0000;
    end
    else
    begin
      sync_prev_q <= regs_q[`SCP_ADDR_OFFA_HI][`SCP_BIT_OFFSET_SYNC];
      // a level held high does nothing; software must clear first
      if (regs_q[`SCP_ADDR_OFFA_HI][`SCP_BIT_OFFSET_SYNC] && !sync_prev_q)
      begin
        PATH_A_OFFSET <= {regs_q[`SCP_ADDR_OFFA_HI][4:0], regs_q[`SCP_ADDR_OFFA_LO]};
        PATH_B_OFFSET <= {regs_q[`SCP_ADDR_OFFB_HI][4:0], regs_q[`SCP_ADDR_OFFB_LO]};
      end
    end
  end

  // pin drivers; one register stage so both pins move together
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      LINK.sdio_d_o <= 1'b0;
      LINK.sdio_d_oe <= 1'b0;
      LINK.sdo_o <= 1'b0;
      LINK.sdo_oe <= 1'b0;
    end
    else
    begin
      // shared pin carries read data only in 3-pin mode
      LINK.sdio_d_oe <= !four_wire && rd_act_q && active;
      LINK.sdio_d_o <= rd_bit_q;
      case (out_sel)
        `SCP_SEL_PLL, `SCP_SEL_DLL, `SCP_SEL_PAT, `SCP_SEL_FIFO, `SCP_SEL_SELF:
        begin
          // status on the output pin wins in either mode
          LINK.sdo_oe <= 1'b1;
          case (out_sel)
            `SCP_SEL_PLL: LINK.sdo_o <= PLL_LOCK;
            `SCP_SEL_DLL: LINK.sdo_o <= DLL_LOCK;
            `SCP_SEL_PAT: LINK.sdo_o <= PATTERN_ERR;
            `SCP_SEL_FIFO: LINK.sdo_o <= FIFO_ERR;
            default: LINK.sdo_o <= SELF_CHECK_ERROR;
          endcase
        end
        default:
        begin
          // normal: 4-pin read data, then low until frame closes
          LINK.sdo_oe <= four_wire && active && (rd_act_q || tail_q);
          LINK.sdo_o <= tail_q ? 1'b0 : rd_bit_q;
        end
      endcase
    end
  end
endmodule : scp_dev

/* File: hdl/scp_host.sv */
// Purpose: host end of the serial configuration port
// Assumes: device mode bit matches FOUR_WIRE at read time
// Notes: makes the serial clock from CLK; read bits sampled late in the high phase
`timescale 1ns/10ps
`include "scp_cfg.svh"
module scp_host
  import scp_pkg::*;
#(
  parameter int HALF = `SCP_HALF_SCLK // system clocks per serial clock phase
)
(
  input wire logic CLK, // system clock
  input wire logic RESET, // synchronous reset, active high
  scp_link_if.host_mp LINK, // serial pins
  input wire logic START, // one-cycle request pulse
  input wire logic READ, // 1 read, 0 write
  input wire logic [1:0] COUNT, // data bytes minus one
  input wire logic [4:0] ADDR, // starting address
  input wire logic [31:0] WDATA, // write bytes, first in [31:24]
  input wire logic FOUR_WIRE, // read from separate output pin
  output logic BUSY, // frame in progress
  output logic DONE, // one-cycle end pulse
  output logic [31:0] RDATA // read bytes, first in [31:24]
);
  generate
    if (HALF < `SCP_MIN_HALF || HALF > 65535)
    begin : g_bad_half
      $error("scp_host: HALF out of range");
    end
  endgenerate

  scp_host_st_e st_q; // frame state
  logic [15:0] div_q; // phase divider
  logic tick; // end of a phase
  logic [39:0] tx_q; // outgoing instruction and data
  logic [5:0] nbits_q; // bits in frame
  logic [5:0] bit_q; // bits done
  logic [31:0] rx_q; // sampled bits
  logic rd_q; // frame is a read
  logic [1:0] cnt_q; // byte count minus one
  logic sdio_m_q, sdio_s_q, sdo_m_q, sdo_s_q; // pin synchronisers

  assign tick = (div_q == 16'(HALF - 1));

  // synchronise both return pins before use
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sdio_m_q <= 1'b1;
      sdio_s_q <= 1'b1;
      sdo_m_q <= 1'b1;
      sdo_s_q <= 1'b1;
    end
    else
    begin
      sdio_m_q <= LINK.sdio_line;
      sdio_s_q <= sdio_m_q;
      sdo_m_q <= LINK.sdo_line;
      sdo_s_q <= sdo_m_q;
    end
  end

  // phase divider, free in every state but H_IDLE
  always_ff @(posedge CLK)
  begin
    if (RESET || st_q == H_IDLE || tick)
    begin
      div_q <= 16'h0000;
    end
    else
    begin
      div_q <= div_q + 16'h0001;
    end
  end

  // frame sequencer
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_q <= H_IDLE;
      LINK.sclk <= 1'b0;
      LINK.frame_enable_n <= 1'b1;
      LINK.sdio_h_o <= 1'b0;
      LINK.sdio_h_oe <= 1'b0;
      tx_q <= 40'h0000000000;
      nbits_q <= 6'h00;
      bit_q <= 6'h00;
      rx_q <= 32'h00000000;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      RDATA <= 32'h00000000;
    end
    else
    begin
      DONE <= 1'b0;
      unique case (st_q)
        H_IDLE:
        begin
          if (START)
          begin
            // instruction then data, msb first
            tx_q <= {READ, COUNT, ADDR, WDATA};
            nbits_q <= {({1'b0, COUNT} + 3'h2), 3'h0};
            bit_q <= 6'h00;
            rd_q <= READ;
            cnt_q <= COUNT;
            LINK.frame_enable_n <= 1'b0;
            LINK.sdio_h_oe <= 1'b1;
            LINK.sdio_h_o <= READ;
            BUSY <= 1'b1;
            st_q <= H_LEAD;
          end
        end
        H_LEAD:
        begin
          if (tick)
          begin
            LINK.sclk <= 1'b1;
            st_q <= H_RUN;
          end
        end
        H_RUN:
        begin
          if (tick && LINK.sclk)
          begin
            // sample at the end of the high phase, then fall
            LINK.sclk <= 1'b0;
            rx_q <= {rx_q[30:0], FOUR_WIRE ? sdo_s_q : sdio_s_q};
            bit_q <= bit_q + 6'h01;
            if (bit_q == nbits_q - 6'h01)
            begin
              st_q <= H_TRAIL;
              LINK.sdio_h_oe <= 1'b0;
            end
            else
            begin
              tx_q <= {tx_q[38:0], 1'b0};
              LINK.sdio_h_o <= tx_q[38];
              if (rd_q && bit_q == 6'h07)
              begin
                // hand the shared pin over for read data
                LINK.sdio_h_oe <= 1'b0;
              end
            end
          end
          else if (tick)
          begin
            LINK.sclk <= 1'b1;
          end
        end
        H_TRAIL:
        begin
          if (tick)
          begin
            LINK.frame_enable_n <= 1'b1;
            st_q <= H_GAP;
            if (rd_q)
            begin
              RDATA <= rx_q << {2'h3 - cnt_q, 3'h0};
            end
          end
        end
        H_GAP:
        begin
          if (tick)
          begin
            BUSY <= 1'b0;
            DONE <= 1'b1;
            st_q <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : scp_host

/* File: tb/scp_link_checker.sv */
// Purpose: watches the serial link between host and device ends
// Assumes: sclk is made by the host from CLK and idles low
// Notes: a frame is judged by the sclk rising edges counted inside it
`timescale 1ns/10ps
module scp_link_checker (
  input wire logic CLK, // system clock
  input wire logic RESET, // sync reset, active high
  input wire logic sclk, // serial clock
  input wire logic frame_enable_n, // frame, active low
  input wire logic sdio_h_o, // host data
  input wire logic sdio_h_oe, // host drives data pin
  input wire logic sdio_d_o, // device data
  input wire logic sdio_d_oe, // device drives data pin
  input wire logic sdo_o, // output pin value
  input wire logic sdo_oe // output pin enable
);
  logic sclk_q; // sclk one CLK ago
  logic [5:0] bits_q; // sclk rises seen in this frame
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // delayed sclk for edge finding
  always_ff @(posedge CLK)
    sclk_q <= RESET ? 1'b0 : sclk;
  // bit counter, cleared outside frames so a frame always starts at zero
  always_ff @(posedge CLK)
  begin
    if (RESET || frame_enable_n)
      bits_q <= 6'h00;
    else if (sclk && !sclk_q)
      bits_q <= bits_q + 6'h01;
  end
  a_no_contention: assert property (!(sdio_h_oe && sdio_d_oe))
    else $error("both ends drive the data pin");
  a_sclk_idle_low: assert property (frame_enable_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_frame_edge_low: assert property ($changed(frame_enable_n) |-> !sclk)
    else $error("frame edge while serial clock high");
  a_frame_bytes: assert property ($rose(frame_enable_n) |-> bits_q inside {6'h10, 6'h18, 6'h20, 6'h28})
    else $error("frame not two to five whole bytes");
  a_host_bit_stable: assert property (sclk && $past(sclk) && sdio_h_oe |-> $stable(sdio_h_o))
    else $error("host data moved while serial clock high");
  a_dev_launch_low: assert property (sdio_d_oe && $changed(sdio_d_o) |-> !sclk)
    else $error("device data moved while serial clock high");
  a_sdo_launch_low: assert property (sdo_oe && $past(sdo_oe) && !frame_enable_n && $changed(sdo_o) |-> !sclk)
    else $error("output pin moved while serial clock high");
  a_instr_quiet: assert property (sdio_d_oe && !frame_enable_n |-> bits_q >= 6'h08)
    else $error("device drove data pin during instruction");
  a_idle_quiet: assert property (frame_enable_n [*6] |-> !sdio_d_oe)
    else $error("device drove data pin between frames");
endmodule : scp_link_checker

/* File: tb/tb.sv */
// Purpose: self-checking bench joining host and device ends
// Assumes: HALF of 8 keeps device launches well inside the low phase
// Notes: read results compared on the top bytes only
`timescale 1ns/10ps
`include "scp_cfg.svh"
module tb;
  logic CLK = 1'b0; // system clock
  logic RESET = 1'b1; // sync reset
  logic start = 1'b0; // host request
  logic rd = 1'b0; // read request
  logic four = 1'b0; // host reads output pin
  logic [1:0] cnt = 2'h0; // bytes minus one
  logic [4:0] ad = 5'h00; // start address
  logic [31:0] wd = 32'h0; // write bytes
  logic [4:0] st = 5'h00; // status inputs
  logic busy, done; // host status
  logic [31:0] rdata; // host read bytes
  logic [12:0] offa, offb; // working offsets
  logic [3:0] vr; // vco range
  logic [1:0] vg; // vco gain
  logic fws; // port mode
  logic fe_prev = 1'b1, sdo_prev = 1'b1, tail = 1'b1; // output pin at frame close
  int fails = 0, tests_run = 0, cyc = 0; // counters
  scp_link_if scp_link_if_i ();
  scp_host #(.HALF(8)) scp_host_i (.CLK(CLK), .RESET(RESET), .LINK(scp_link_if_i),
    .START(start),
    .READ(rd), .COUNT(cnt), .ADDR(ad), .WDATA(wd), .FOUR_WIRE(four), .BUSY(busy),
    .DONE(done), .RDATA(rdata));
  scp_dev scp_dev_i (.CLK(CLK), .RESET(RESET), .LINK(scp_link_if_i), .PLL_LOCK(st[0]),
    .DLL_LOCK(st[1]), .PATTERN_ERR(st[2]), .FIFO_ERR(st[3]), .SELF_CHECK_ERROR(st[4]),
    .PATH_A_OFFSET(offa), .PATH_B_OFFSET(offb), .VCO_RANGE(vr), .VCO_GAIN(vg),
    .FOUR_WIRE_SELECT(fws));
  scp_link_checker scp_link_checker_i (.CLK(CLK), .RESET(RESET), .sclk(scp_link_if_i.sclk),
    .frame_enable_n(scp_link_if_i.frame_enable_n), .sdio_h_o(scp_link_if_i.sdio_h_o),
    .sdio_h_oe(scp_link_if_i.sdio_h_oe), .sdio_d_o(scp_link_if_i.sdio_d_o),
    .sdio_d_oe(scp_link_if_i.sdio_d_oe), .sdo_o(scp_link_if_i.sdo_o),
    .sdo_oe(scp_link_if_i.sdo_oe));
  always #10 CLK = ~CLK;
  // remember the output pin level just before the frame enable rises
  always @(posedge CLK)
  begin
    fe_prev <= scp_link_if_i.frame_enable_n;
    sdo_prev <= scp_link_if_i.sdo_line;
    if (scp_link_if_i.frame_enable_n && !fe_prev)
      tail <= sdo_prev;
  end
  // hang guard, well above the length of all frames
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      test_done();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // one host frame, waits on the done pulse
  task xfer(input logic r, input logic [1:0] c, input logic [4:0] a, input logic [31:0] w);
    int n;
    @(posedge CLK);
    start <= 1'b1;
    rd <= r;
    cnt <= c;
    ad <= a;
    wd <= w;
    @(posedge CLK);
    start <= 1'b0;
    // the request was taken at this edge, so the frame is now running
    @(negedge CLK);
    chk("busy", busy, 32'h1);
    n = 0;
    while (done !== 1'b1 && n < 2000)
    begin
      @(negedge CLK);
      n++;
    end
    chk("done", n < 2000, 32'h1);
    chk("idle", busy, 32'h0);
    repeat (4) @(negedge CLK);
  endtask : xfer
  task wr(input logic [4:0] a, input logic [7:0] b);
    xfer(1'b0, 2'h0, a, {b, 24'h0});
  endtask : wr
  // unused low bytes of rdata are zero, so shift the read bytes down to the bottom
  task rdchk(input string nm, input logic [1:0] c, input logic [4:0] a, input logic [31:0] e);
    xfer(1'b1, c, a, 32'h0);
    chk(nm, rdata >> (8 * (3 - c)), e);
  endtask : rdchk
  task t_reset;
    chk("offa", offa, 32'h0);
    chk("vco", {vg, vr}, 32'h0);
    chk("mode", fws, 32'h0);
  endtask : t_reset
  // four byte write from 0x0E down to 0x0B, offsets still held back
  task t_regs;
    xfer(1'b0, 2'h3, `SCP_ADDR_OUTSEL, 32'h00A51F2B);
    chk("range", vr, 32'hB);
    chk("gain", vg, 32'h2);
    chk("offa", offa, 32'h0);
  endtask : t_regs
  task t_sync;
    wr(`SCP_ADDR_OFFA_HI, 8'h3F);
    chk("offa", offa, 32'h1FA5);
    xfer(1'b0, 2'h1, `SCP_ADDR_OFFB_LO, 32'h34120000);
    chk("offb", offb, 32'h0);
    wr(`SCP_ADDR_OFFA_HI, 8'h1F);
    wr(`SCP_ADDR_OFFA_HI, 8'h3F);
    chk("offb", offb, 32'h1234);
    wr(`SCP_ADDR_RSVD_F, 8'h00);
  endtask : t_sync
  task t_read3;
    rdchk("burst", 2'h3, `SCP_ADDR_OUTSEL, 32'h00A53F2B);
    chk("tail3", tail, 32'h1);
    rdchk("unmapped", 2'h0, 5'h00, 32'h0);
    rdchk("rsvd", 2'h0, `SCP_ADDR_RSVD_F, 32'h0);
  endtask : t_read3
  task t_four;
    wr(`SCP_ADDR_CTRL, 8'h80);
    chk("mode", fws, 32'h1);
    @(posedge CLK);
    four <= 1'b1;
    rdchk("four", 2'h1, `SCP_ADDR_OFFA_LO, 32'hA53F);
    chk("tail4", tail, 32'h0);
  endtask : t_four
  // each code routes exactly one status input; 6 and 7 give normal reads
  task t_status;
    // status inputs move only on a rising edge and never inside a frame
    for (int i = 1; i < 8; i++)
    begin
      @(posedge CLK);
      st <= 5'h00;
      wr(`SCP_ADDR_OUTSEL, {i[2:0], 5'h00});
      if (i < 6)
      begin
        @(posedge CLK);
        st <= 5'h01 << (i - 1);
        repeat (3) @(negedge CLK);
        chk("stat1", scp_link_if_i.sdo_line, 32'h1);
        @(posedge CLK);
        st <= ~(5'h01 << (i - 1));
        repeat (3) @(negedge CLK);
        chk("stat0", scp_link_if_i.sdo_line, 32'h0);
      end
      else
        rdchk("normal", 2'h0, `SCP_ADDR_OFFA_LO, 32'hA5);
    end
    @(posedge CLK);
    st <= 5'h00;
    wr(`SCP_ADDR_OUTSEL, 8'h20);
    @(posedge CLK);
    st <= 5'h01;
    rdchk("override", 2'h0, `SCP_ADDR_OFFA_LO, 32'hFF);
    @(posedge CLK);
    st <= 5'h00;
    wr(`SCP_ADDR_OUTSEL, 8'h00);
  endtask : t_status
  task t_reset2;
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    four <= 1'b0;
    @(negedge CLK);
    chk("offb", offb, 32'h0);
    chk("mode", fws, 32'h0);
  endtask : t_reset2
  initial
  begin
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    t_reset();
    t_regs();
    t_sync();
    t_read3();
    t_four();
    t_status();
    t_reset2();
    test_done();
  end
endmodule : tb
